// file: pkg/tsf_pkg.sv
// Shared constants of the temperature sensor filter and status block.
// Assumes a single 20 MHz clock.
package tsf_pkg;

  // Command bytes (register offsets) reached through the register port.
  localparam logic [7:0] CMD_COMMON_STATUS = 8'h02;
  localparam logic [7:0] CMD_CONFIG = 8'h03;
  localparam logic [7:0] CMD_CONV_EN = 8'h05;
  localparam logic [7:0] CMD_FILTER = 8'h06;
  localparam logic [7:0] CMD_DIODE_FAULT = 8'h07;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;

  // Field positions in the main configuration register.
  localparam int STANDBY_BIT = 6;

  // Field positions in the channel conversion enable register.
  localparam int LOCAL_EN_BIT = 0;
  localparam int REMOTE_ONE_EN_BIT = 1;
  localparam int REMOTE_TWO_EN_BIT = 2;

  // Field positions in the filter register.
  localparam int REMOTE_ONE_FILTER_LSB = 0;
  localparam int REMOTE_TWO_FILTER_LSB = 2;

  // Field positions in the common status register.
  localparam int BUSY_BIT = 7;
  localparam int NOT_READY_BIT = 6;
  localparam int FAULT_SUMMARY_BIT = 0;
  localparam int LIMIT_ONE_SUMMARY_BIT = 1;
  localparam int LIMIT_TWO_SUMMARY_BIT = 2;
  localparam int LIMIT_THREE_SUMMARY_BIT = 3;

  // Field positions in the diode fault register.
  localparam int REMOTE_ONE_SHORT_BIT = 0;
  localparam int REMOTE_ONE_OPEN_BIT = 1;
  localparam int REMOTE_TWO_SHORT_BIT = 2;
  localparam int REMOTE_TWO_OPEN_BIT = 3;

  // Reset values.
  localparam logic STANDBY_RST = 1'h0;
  localparam logic [2:0] CONV_EN_RST = 3'h7;
  localparam logic [3:0] FILTER_RST = 4'hF;
  localparam logic [3:0] FAULT_RST = 4'h0;

  // Filter mode encodings; the remaining code 10 is reserved and the host must not write it.
  localparam logic [1:0] FILTER_NONE = 2'h0;
  localparam logic [1:0] FILTER_BASIC = 2'h1;
  localparam logic [1:0] FILTER_ENHANCED = 2'h3;

  // Readings substituted while a remote diode is faulty.
  localparam logic [7:0] FAULT_UNSIGNED_VALUE = 8'h00;
  localparam logic [7:0] FAULT_SIGNED_VALUE = 8'h80;

  // Width of the asynchronous front-end detector group.
  localparam int AFE_FLAG_W = 4;

  // Timing: clock rate, power-up not-ready time and time of one channel conversion.
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned POWERUP_NR_MS = 30;
  localparam int unsigned POWERUP_CYCLES_DFLT = POWERUP_NR_MS * (CLK_HZ / 1000);
  localparam int unsigned CHAN_CONV_US = 10000;
  localparam int unsigned CHAN_CONV_CYCLES_DFLT = CHAN_CONV_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 20;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    TSF_SEQ_IDLE,
    TSF_SEQ_CONVERT,
    TSF_SEQ_FINISH
  } tsf_seq_state_t;

endpackage

// file: rtl/tsf_sync3.sv
// Three-stage synchroniser for the analog front-end detector flags.
// Assumes its inputs change with no relation to clk; a bit is taken once stages two and three agree.
`timescale 1ns/10ps

module tsf_sync3
  import tsf_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Raw flags from outside the clock domain.
  input wire logic [tsf_pkg::AFE_FLAG_W-1:0] async_in,
  // Filtered flags.
  output logic [tsf_pkg::AFE_FLAG_W-1:0] sync_q
);

  logic [AFE_FLAG_W-1:0] meta_q; // First stage, read only by the second stage.
  logic [AFE_FLAG_W-1:0] mid_q; // Second stage.
  logic [AFE_FLAG_W-1:0] last_q; // Third stage.
  logic [AFE_FLAG_W-1:0] sync_d; // Next filtered value.

  // A bit moves only when the two settled stages agree, which rejects one-cycle glitches.
  always_comb begin
    sync_d = sync_q;
    for (int i = 0; i < AFE_FLAG_W; i++) begin
      if (mid_q[i] == last_q[i]) begin
        sync_d[i] = last_q[i];
      end
    end
  end

  // The stages themselves; all clear under reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      mid_q <= '0;
      last_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      mid_q <= meta_q;
      last_q <= mid_q;
      sync_q <= sync_d;
    end
  end

endmodule

// file: rtl/tsf_top.sv
// Register-level control and status of a two-remote-diode plus local temperature sensor.
// Assumes one-cycle command-byte read and write strobes on clk.
// Summary of operation
// RULE_01: Reserved bits of these registers read zero.
// RULE_02: Bits 3-2 select remote two filter.
// RULE_03: Bits 1-0 select remote one filter.
// RULE_04: Host never writes reserved filter code 10.
// RULE_05: Trigger write starts one pass, enabled channels.
// RULE_06: Trigger acts only in standby, never while converting.
// RULE_07: Trigger data byte is discarded, not stored.
// RULE_08: Status bit 7 shows conversion in progress.
// RULE_09: Status bit 6 set during power-up wait.
// RULE_10: Status bits 3-0 OR status registers 1-4.
// RULE_11: Fault register reports open and short per remote.
// RULE_12: Faulty remote reads 0 unsigned, -128 signed.
// RULE_13: Low-pulled diode is short, high-pulled is open.
// RULE_14: Configuration bit 6 selects standby, resets zero.
// RULE_15: Enable bits skip disabled channels in passes.
// RULE_16: Limit bits set at limit, clear below hysteresis.
// RULE_17: Fault bits update when remote conversion completes.
`timescale 1ns/10ps

module tsf_top
  import tsf_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = tsf_pkg::POWERUP_CYCLES_DFLT,
  parameter int unsigned CHAN_CONV_CYCLES = tsf_pkg::CHAN_CONV_CYCLES_DFLT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Command-byte register port from the serial engine.
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Limit status registers two to four, kept by the comparison logic.
  input wire logic [2:0] limit_one_status,
  input wire logic [2:0] limit_two_status,
  input wire logic [2:0] limit_three_status,
  // Asynchronous diode detectors, index 0 remote one, index 1 remote two.
  input wire logic [1:0] diode_pulled_low,
  input wire logic [1:0] diode_pulled_high,
  // Raw readings of the remote channels in both formats.
  input wire logic [7:0] remote_one_raw_unsigned,
  input wire logic [7:0] remote_one_raw_signed,
  input wire logic [7:0] remote_two_raw_unsigned,
  input wire logic [7:0] remote_two_raw_signed,
  // Conversion control towards the front end.
  output logic conv_active_q,
  output logic [1:0] conv_chan_q,
  output logic [1:0] remote_one_filter_mode_q,
  output logic [1:0] remote_two_filter_mode_q,
  // Reported remote readings with fault substitution.
  output logic [7:0] remote_one_unsigned_q,
  output logic [7:0] remote_one_signed_q,
  output logic [7:0] remote_two_unsigned_q,
  output logic [7:0] remote_two_signed_q
);

  // Channel numbers used by the sequencer.
  localparam logic [1:0] CHAN_LOCAL = 2'h0;
  localparam logic [1:0] CHAN_REMOTE_ONE = 2'h1;
  localparam logic [1:0] CHAN_REMOTE_TWO = 2'h2;
  localparam logic [1:0] CHAN_NONE = 2'h3;
  localparam logic [CNT_W-1:0] PWR_LAST = CNT_W'(POWERUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CHAN_CONV_CYCLES - 1);

  // Returns the first enabled channel at or after the given one, or none.
  function automatic logic [1:0] next_chan(input logic [1:0] from, input logic [2:0] en);
    logic [1:0] found;
    found = CHAN_NONE;
    for (int c = 2; c >= 0; c--) begin
      if (2'(c) >= from && en[c]) begin
        found = 2'(c);
      end
    end
    return found;
  endfunction

  // Replaces a reading with the fault value while the channel has a fault.
  function automatic logic [7:0] subst(input logic [7:0] raw, input logic fault,
                                       input logic [7:0] fault_val);
    return fault ? fault_val : raw;
  endfunction

  // Configuration state written by the host.
  logic standby_select_q; // One selects standby.
  logic standby_select_d;
  logic [2:0] conv_en_q; // Remote two, remote one, local enables.
  logic [2:0] conv_en_d;
  logic [1:0] remote_one_filter_mode_d;
  logic [1:0] remote_two_filter_mode_d;

  // Sequencer and power-up state.
  tsf_seq_state_t seq_q; // Conversion sequencer state.
  tsf_seq_state_t seq_d;
  logic [1:0] conv_chan_d;
  logic conv_active_d;
  logic [CNT_W-1:0] conv_cnt_q; // Cycles spent on the current channel.
  logic [CNT_W-1:0] conv_cnt_d;
  logic [CNT_W-1:0] pwr_cnt_q; // Cycles since reset release.
  logic [CNT_W-1:0] pwr_cnt_d;
  logic powerup_not_ready_q; // High during the power-up wait.
  logic powerup_not_ready_d;

  // Fault state and readback.
  logic [3:0] fault_q; // Diode fault register, bits 3 to 0.
  logic [3:0] fault_d;
  logic [3:0] afe_sync; // Synchronised detectors: high pair then low pair.
  logic [7:0] rdata_d;
  logic [7:0] common_status;
  logic one_shot_wr; // Host wrote the trigger register this cycle.
  logic chan_done; // Current channel conversion ends this cycle.
  logic [7:0] r1u_d;
  logic [7:0] r1s_d;
  logic [7:0] r2u_d;
  logic [7:0] r2s_d;

  // The front-end detectors come from the analog side and need filtering before use.
  tsf_sync3 u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({diode_pulled_high, diode_pulled_low}),
    .sync_q(afe_sync)
  );

  // Configuration registers. The trigger register has no storage at all.
  always_comb begin
    standby_select_d = standby_select_q;
    conv_en_d = conv_en_q;
    remote_one_filter_mode_d = remote_one_filter_mode_q;
    remote_two_filter_mode_d = remote_two_filter_mode_q;
    if (reg_wr) begin
      unique case (reg_cmd)
        CMD_CONFIG: begin
          standby_select_d = reg_wdata[STANDBY_BIT]; // [RULE_14]
        end
        CMD_CONV_EN: begin
          conv_en_d = reg_wdata[REMOTE_TWO_EN_BIT:LOCAL_EN_BIT]; // [RULE_15]
        end
        CMD_FILTER: begin
          // The reserved code 10 is stored as written; the host must not use it.
          remote_two_filter_mode_d = reg_wdata[REMOTE_TWO_FILTER_LSB+:2]; // [RULE_02]
          remote_one_filter_mode_d = reg_wdata[REMOTE_ONE_FILTER_LSB+:2]; // [RULE_03]
        end
        default: begin
          // Read-only and unmapped commands ignore writes.
        end
      endcase
    end
  end

  // Register the configuration.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      standby_select_q <= STANDBY_RST;
      conv_en_q <= CONV_EN_RST;
      remote_one_filter_mode_q <= FILTER_RST[1:0];
      remote_two_filter_mode_q <= FILTER_RST[3:2];
    end else begin
      standby_select_q <= standby_select_d;
      conv_en_q <= conv_en_d;
      remote_one_filter_mode_q <= remote_one_filter_mode_d;
      remote_two_filter_mode_q <= remote_two_filter_mode_d;
    end
  end

  // Power-up wait: not ready until the count expires, and no conversion runs before that.
  always_comb begin
    pwr_cnt_d = pwr_cnt_q;
    powerup_not_ready_d = powerup_not_ready_q;
    if (powerup_not_ready_q) begin
      if (pwr_cnt_q == PWR_LAST) begin
        powerup_not_ready_d = 1'b0; // [RULE_09]
      end else begin
        pwr_cnt_d = pwr_cnt_q + CNT_W'(1);
      end
    end
  end

  // Register the power-up state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_cnt_q <= '0;
      powerup_not_ready_q <= 1'b1;
    end else begin
      pwr_cnt_q <= pwr_cnt_d;
      powerup_not_ready_q <= powerup_not_ready_d;
    end
  end

  // The data byte is never looked at, only the command.
  assign one_shot_wr = reg_wr && (reg_cmd == CMD_ONE_SHOT); // [RULE_07]
  assign chan_done = (seq_q == TSF_SEQ_CONVERT) && (conv_cnt_q == CONV_LAST);

  // Conversion sequencer. Active mode restarts a pass whenever idle; standby waits
  // for a trigger. A trigger while busy or outside standby is dropped, not queued.
  always_comb begin
    seq_d = seq_q;
    conv_chan_d = conv_chan_q;
    conv_active_d = conv_active_q;
    conv_cnt_d = conv_cnt_q;
    unique case (seq_q)
      TSF_SEQ_IDLE: begin
        conv_cnt_d = '0;
        if (!powerup_not_ready_q &&
            (!standby_select_q || one_shot_wr)) begin // [RULE_05] [RULE_06]
          conv_chan_d = next_chan(CHAN_LOCAL, conv_en_q); // [RULE_15]
          // With every channel disabled the pass is empty and ends at once.
          if (next_chan(CHAN_LOCAL, conv_en_q) != CHAN_NONE) begin
            seq_d = TSF_SEQ_CONVERT;
            conv_active_d = 1'b1; // [RULE_08]
          end
        end
      end
      TSF_SEQ_CONVERT: begin
        if (chan_done) begin
          conv_cnt_d = '0;
          if (conv_chan_q == CHAN_REMOTE_TWO ||
              next_chan(conv_chan_q + 2'h1, conv_en_q) == CHAN_NONE) begin
            seq_d = TSF_SEQ_FINISH;
          end else begin
            conv_chan_d = next_chan(conv_chan_q + 2'h1, conv_en_q); // [RULE_15]
          end
        end else begin
          conv_cnt_d = conv_cnt_q + CNT_W'(1);
        end
      end
      TSF_SEQ_FINISH: begin
        // One idle cycle between passes keeps busy low long enough to be seen.
        conv_active_d = 1'b0; // [RULE_08]
        seq_d = TSF_SEQ_IDLE;
      end
      default: begin
        seq_d = TSF_SEQ_IDLE;
        conv_active_d = 1'b0;
      end
    endcase
  end

  // Register the sequencer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= TSF_SEQ_IDLE;
      conv_chan_q <= CHAN_LOCAL;
      conv_active_q <= 1'b0;
      conv_cnt_q <= '0;
    end else begin
      seq_q <= seq_d;
      conv_chan_q <= conv_chan_d;
      conv_active_q <= conv_active_d;
      conv_cnt_q <= conv_cnt_d;
    end
  end

  // Fault bits are sampled only as a remote conversion completes, so a flag that
  // flickers between conversions does not reach the register.
  always_comb begin
    fault_d = fault_q;
    if (chan_done && conv_chan_q == CHAN_REMOTE_ONE) begin // [RULE_17]
      fault_d[REMOTE_ONE_SHORT_BIT] = afe_sync[0]; // [RULE_13] [RULE_11]
      fault_d[REMOTE_ONE_OPEN_BIT] = afe_sync[2] && !afe_sync[0]; // [RULE_13] [RULE_11]
    end
    if (chan_done && conv_chan_q == CHAN_REMOTE_TWO) begin // [RULE_17]
      fault_d[REMOTE_TWO_SHORT_BIT] = afe_sync[1]; // [RULE_13] [RULE_11]
      fault_d[REMOTE_TWO_OPEN_BIT] = afe_sync[3] && !afe_sync[1]; // [RULE_13] [RULE_11]
    end
  end

  // Register the fault state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_q <= FAULT_RST;
    end else begin
      fault_q <= fault_d;
    end
  end

  // Reported readings follow the raw values unless the channel is faulty.
  always_comb begin
    r1u_d = subst(remote_one_raw_unsigned, |fault_q[1:0], FAULT_UNSIGNED_VALUE); // [RULE_12]
    r1s_d = subst(remote_one_raw_signed, |fault_q[1:0], FAULT_SIGNED_VALUE); // [RULE_12]
    r2u_d = subst(remote_two_raw_unsigned, |fault_q[3:2], FAULT_UNSIGNED_VALUE); // [RULE_12]
    r2s_d = subst(remote_two_raw_signed, |fault_q[3:2], FAULT_SIGNED_VALUE); // [RULE_12]
  end

  // Register the reported readings.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remote_one_unsigned_q <= FAULT_UNSIGNED_VALUE;
      remote_one_signed_q <= FAULT_UNSIGNED_VALUE;
      remote_two_unsigned_q <= FAULT_UNSIGNED_VALUE;
      remote_two_signed_q <= FAULT_UNSIGNED_VALUE;
    end else begin
      remote_one_unsigned_q <= r1u_d;
      remote_one_signed_q <= r1s_d;
      remote_two_unsigned_q <= r2u_d;
      remote_two_signed_q <= r2s_d;
    end
  end

  // Common status is built from live state; bits 5 and 4 stay zero.
  always_comb begin
    common_status = 8'h00; // [RULE_01]
    common_status[BUSY_BIT] = conv_active_q; // [RULE_08]
    common_status[NOT_READY_BIT] = powerup_not_ready_q; // [RULE_09]
    common_status[FAULT_SUMMARY_BIT] = |fault_q; // [RULE_10]
    common_status[LIMIT_ONE_SUMMARY_BIT] = |limit_one_status; // [RULE_10] [RULE_16]
    common_status[LIMIT_TWO_SUMMARY_BIT] = |limit_two_status; // [RULE_10] [RULE_16]
    common_status[LIMIT_THREE_SUMMARY_BIT] = |limit_three_status; // [RULE_10] [RULE_16]
  end

  // Read multiplexer; every reserved bit is padded with zero and the trigger reads zero.
  always_comb begin
    rdata_d = 8'h00; // [RULE_01]
    unique case (reg_cmd)
      CMD_COMMON_STATUS: begin
        rdata_d = common_status;
      end
      CMD_CONFIG: begin
        rdata_d[STANDBY_BIT] = standby_select_q; // [RULE_01]
      end
      CMD_CONV_EN: begin
        rdata_d[2:0] = conv_en_q; // [RULE_01]
      end
      CMD_FILTER: begin
        rdata_d[3:0] = {remote_two_filter_mode_q, remote_one_filter_mode_q}; // [RULE_01]
      end
      CMD_DIODE_FAULT: begin
        rdata_d[3:0] = fault_q; // [RULE_01] [RULE_11]
      end
      default: begin
        rdata_d = 8'h00; // [RULE_07]
      end
    endcase
  end

  // Read data is captured on the strobe and held until the next read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

endmodule

// file: tb/tsf_asserts.sv
// Port-level checks of the sensor filter and status block.
// Assumes one clock domain.
`timescale 1ns/10ps

module tsf_asserts
  import tsf_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = 20,
  parameter int unsigned CHAN_CONV_CYCLES = 5
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  // Limit status inputs.
  input wire logic [2:0] limit_one_status,
  input wire logic [2:0] limit_two_status,
  input wire logic [2:0] limit_three_status,
  // Conversion and filter outputs.
  input wire logic conv_active_q,
  input wire logic [1:0] conv_chan_q,
  input wire logic [1:0] remote_one_filter_mode_q,
  input wire logic [1:0] remote_two_filter_mode_q
);
  // Edges since reset, and cycles on the current channel.
  logic [15:0] up_q, up_d, seg_q, seg_d;
  logic act_prev_q;
  logic [1:0] chan_prev_q;

  // Helper counters keep long spans out of repetitions.
  always_comb begin
    up_d = (up_q == 16'hFFFF) ? up_q : up_q + 16'h1;
    seg_d = 16'h0;
    if (conv_active_q) begin
      seg_d = (act_prev_q && conv_chan_q == chan_prev_q) ? seg_q + 16'h1 : 16'h1;
    end
  end

  // Registers of the helper counters.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_q <= 16'h0;
      seg_q <= 16'h0;
      act_prev_q <= 1'b0;
      chan_prev_q <= 2'h0;
    end else begin
      up_q <= up_d;
      seg_q <= seg_d;
      act_prev_q <= conv_active_q;
      chan_prev_q <= conv_chan_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  read_answer_a: assert property (reg_rd |=> reg_rvalid_q) else $error("read not answered");
  valid_pulse_a: assert property (!reg_rd |=> !reg_rvalid_q) else $error("stray read valid");
  filter_write_a: assert property (reg_wr && reg_cmd == CMD_FILTER |=>
    {4'h0, remote_two_filter_mode_q, remote_one_filter_mode_q} == ($past(reg_wdata) & 8'h0F))
    else $error("filter fields differ from write");
  filter_hold_a: assert property (!(reg_wr && reg_cmd == CMD_FILTER) |=>
    $stable({remote_two_filter_mode_q, remote_one_filter_mode_q})) else $error("filter moved");
  trig_discard_a: assert property (reg_rd && reg_cmd == CMD_ONE_SHOT |=>
    reg_rdata_q == 8'h00) else $error("trigger data kept");
  reserved_zero_a: assert property (reg_rd && (reg_cmd == CMD_FILTER ||
    reg_cmd == CMD_DIODE_FAULT || reg_cmd == CMD_COMMON_STATUS) |=> (reg_rdata_q &
    ($past(reg_cmd) == CMD_COMMON_STATUS ? 8'h30 : 8'hF0)) == 8'h00) else $error("reserved set");
  summary_or_a: assert property (reg_rd && reg_cmd == CMD_COMMON_STATUS |=>
    reg_rdata_q[3:1] == {|$past(limit_three_status), |$past(limit_two_status),
    |$past(limit_one_status)}) else $error("summary flags wrong");
  busy_bit_a: assert property (reg_rd && reg_cmd == CMD_COMMON_STATUS |=>
    reg_rdata_q[7] == $past(conv_active_q)) else $error("busy bit wrong");
  not_ready_a: assert property (reg_rd && reg_cmd == CMD_COMMON_STATUS &&
    (up_q + 2 <= POWERUP_CYCLES || up_q >= POWERUP_CYCLES + 2) |=>
    reg_rdata_q[6] == ($past(up_q) < POWERUP_CYCLES)) else $error("not-ready bit wrong");
  no_early_conv_a: assert property (conv_active_q |-> up_q > POWERUP_CYCLES)
    else $error("conversion during power-up");
  chan_step_a: assert property (conv_active_q && act_prev_q && conv_chan_q != chan_prev_q
    |-> conv_chan_q > chan_prev_q && seg_q == CHAN_CONV_CYCLES) else $error("channel step wrong");
  pass_end_a: assert property (!conv_active_q && act_prev_q |->
    seg_q == CHAN_CONV_CYCLES + 1) else $error("pass ended early or late");

  // Scenarios reached.
  trig_c: cover property (reg_wr && reg_cmd == CMD_ONE_SHOT && !conv_active_q);
  pass_c: cover property (!conv_active_q && act_prev_q);
  step_c: cover property (conv_active_q && act_prev_q && conv_chan_q != chan_prev_q);
endmodule

bind tsf_top tsf_asserts #(
  .POWERUP_CYCLES(POWERUP_CYCLES),
  .CHAN_CONV_CYCLES(CHAN_CONV_CYCLES)
) i_asserts (.*);

// file: tb/tsf_host_model.sv
// Host side of the command-byte register port.
// Assumes requests launched on falling edges.
`timescale 1ns/10ps

module tsf_host_model (
  // Clock.
  input wire logic clk,
  // Requests towards the block.
  output logic [7:0] reg_cmd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  // Answers from the block.
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q
);
  // Idle bus starts quiet.
  initial begin
    reg_cmd = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // One write; released fields show the inverse.
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clk);
    reg_cmd = cmd;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_cmd = ~cmd;
    reg_wdata = ~data;
  endtask

  // One read; the answer is taken as the strobe drops.
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
    @(negedge clk);
    reg_cmd = cmd;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_cmd = ~cmd;
    ok = reg_rvalid_q;
    data = reg_rdata_q;
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the sensor filter and status block.
// Assumes short power-up and channel counts so the run stays brief.
`timescale 1ns/10ps

module tb_top;
  import tsf_pkg::*;
  localparam int unsigned NPWR = 20;
  localparam int unsigned NCH = 5;
  localparam logic [7:0] RAW1U = 8'h3C;
  localparam logic [7:0] RAW1S = 8'h1C;
  localparam logic [7:0] RAW2U = 8'h51;
  localparam logic [7:0] RAW2S = 8'h31;
  logic clk, rst_b, reg_wr, reg_rd, reg_rvalid_q, rd_ok, conv_active_q;
  logic [7:0] reg_cmd, reg_wdata, reg_rdata_q, rd_data, rep1u, rep1s, rep2u, rep2s;
  logic [1:0] conv_chan_q, r1_mode, r2_mode, pulled_low, pulled_high;
  logic [2:0] lim1, lim2, lim3;
  int n_mismatch, num_checks;
  // Only legal filter codes are written.
  logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
  // Detector cases: pulled low, pulled high, expected fault byte.
  logic [1:0] lows [3] = '{2'h1, 2'h2, 2'h0};
  logic [1:0] highs [3] = '{2'h2, 2'h3, 2'h0};
  logic [7:0] fexp [3] = '{8'h09, 8'h06, 8'h00};

  tsf_host_model i_host (.clk(clk), .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));

  tsf_top #(.POWERUP_CYCLES(NPWR), .CHAN_CONV_CYCLES(NCH)) i_dut (
    .clk(clk), .rst_b(rst_b), .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .limit_one_status(lim1), .limit_two_status(lim2), .limit_three_status(lim3),
    .diode_pulled_low(pulled_low), .diode_pulled_high(pulled_high),
    .remote_one_raw_unsigned(RAW1U), .remote_one_raw_signed(RAW1S),
    .remote_two_raw_unsigned(RAW2U), .remote_two_raw_signed(RAW2S),
    .conv_active_q(conv_active_q), .conv_chan_q(conv_chan_q),
    .remote_one_filter_mode_q(r1_mode), .remote_two_filter_mode_q(r2_mode),
    .remote_one_unsigned_q(rep1u), .remote_one_signed_q(rep1s),
    .remote_two_unsigned_q(rep2u), .remote_two_signed_q(rep2s));

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  // Compare one value and count it.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read one register; check the strobe and the byte.
  task automatic read_check(input logic [7:0] cmd, input logic [7:0] exp, input string what);
    i_host.rd(cmd, rd_data, rd_ok);
    check("read valid", {7'h0, rd_ok}, 8'h01);
    check(what, rd_data, exp);
  endtask

  // Trigger one pass and time it; optionally retrigger while busy.
  task automatic one_pass(input logic [2:0] en, input logic again);
    int n;
    n = int'(en[0]) + int'(en[1]) + int'(en[2]);
    i_host.wr(CMD_CONV_EN, {5'h0, en});
    i_host.wr(CMD_ONE_SHOT, 8'hA5);
    @(negedge clk);
    check("busy at start", {7'h0, conv_active_q}, {7'h0, n > 0});
    if (n > 0) begin
      check("first channel", {6'h0, conv_chan_q}, en[0] ? 8'h0 : (en[1] ? 8'h1 : 8'h2));
      if (again) begin
        i_host.wr(CMD_ONE_SHOT, 8'h00);
      end
      repeat (n * NCH - (again ? 3 : 1)) @(negedge clk);
      check("busy in finish", {7'h0, conv_active_q}, 8'h01);
      @(negedge clk);
      check("busy after pass", {7'h0, conv_active_q}, 8'h00);
    end
    repeat (10) @(negedge clk);
    check("no second pass", {7'h0, conv_active_q}, 8'h00);
  endtask

  // Verdict and end of run.
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well above the length of the sequence.
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    results();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    lim1 = 3'h0;
    lim2 = 3'h0;
    lim3 = 3'h0;
    pulled_low = 2'h0;
    pulled_high = 2'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    check("filter modes", {4'h0, r2_mode, r1_mode}, {4'h0, FILTER_RST});
    read_check(CMD_COMMON_STATUS, 8'h40, "status at power-up");
    read_check(CMD_FILTER, 8'h0F, "filter reset");
    // Every legal code pair, reserved bits written as ones.
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        i_host.wr(CMD_FILTER, {4'hF, codes[i], codes[j]});
        read_check(CMD_FILTER, {4'h0, codes[i], codes[j]}, "filter");
        check("filter out", {4'h0, r2_mode, r1_mode}, {4'h0, codes[i], codes[j]});
      end
    end
    read_check(CMD_ONE_SHOT, 8'h00, "trigger readback");
    read_check(8'h1E, 8'h00, "unmapped read");
    // Summary flags; busy is masked as its phase varies.
    lim1 = 3'h2;
    lim3 = 3'h1;
    i_host.rd(CMD_COMMON_STATUS, rd_data, rd_ok);
    check("summary a", rd_data & 8'h7F, 8'h0A);
    lim1 = 3'h0;
    lim2 = 3'h4;
    lim3 = 3'h0;
    i_host.rd(CMD_COMMON_STATUS, rd_data, rd_ok);
    check("summary b", rd_data & 8'h7F, 8'h04);
    lim2 = 3'h0;
    // Standby: the running pass ends and nothing starts until a trigger.
    i_host.wr(CMD_CONFIG, 8'h40);
    for (int k = 0; k < 100 && conv_active_q !== 1'b0; k++) @(negedge clk);
    repeat (10) @(negedge clk);
    check("standby idle", {7'h0, conv_active_q}, 8'h00);
    read_check(CMD_COMMON_STATUS, 8'h00, "status idle");
    one_pass(3'h2, 1'b1);
    one_pass(3'h0, 1'b0);
    // Faults are taken at a full pass; the detectors settle first.
    for (int t = 0; t < 3; t++) begin
      pulled_low = lows[t];
      pulled_high = highs[t];
      repeat (8) @(negedge clk);
      one_pass(3'h7, 1'b0);
      read_check(CMD_DIODE_FAULT, fexp[t], "diode fault");
      read_check(CMD_COMMON_STATUS, {7'h0, |fexp[t]}, "fault summary");
      check("r1 unsigned", rep1u, |fexp[t][1:0] ? FAULT_UNSIGNED_VALUE : RAW1U);
      check("r1 signed", rep1s, |fexp[t][1:0] ? FAULT_SIGNED_VALUE : RAW1S);
      check("r2 unsigned", rep2u, |fexp[t][3:2] ? FAULT_UNSIGNED_VALUE : RAW2U);
      check("r2 signed", rep2s, |fexp[t][3:2] ? FAULT_SIGNED_VALUE : RAW2S);
    end
    results();
  end
endmodule
